// ### logic/plcfg_pkg.sv
// Package: register map, field layout and encodings of the pattern/PLL config block
package plcfg_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] PLCFG_CFG_OFFS = 8'h1a;
  localparam logic [7:0] PLCFG_REFSEL_OFFS = 8'h1b;
  localparam logic [7:0] PLCFG_STATUS_OFFS = 8'h1c;
  // ****************************************
  // Field layout and reset values
  // ****************************************
  localparam int PLCFG_CFG_W = 14;
  localparam int PLCFG_PLEN_LSB = 0;
  localparam int PLCFG_PLEN_MSB = 2;
  localparam int PLCFG_PLLEN_BIT = 10;
  localparam int PLCFG_REFSEL_BIT = 0;
  localparam logic [13:0] PLCFG_CFG_RESET = 14'h0000;
  localparam logic [7:0] PLCFG_REFSEL_RESET = 8'h00;
  localparam int PLCFG_DEPTH_W = 7;
  // ****************************************
  // Encodings
  // ****************************************
  typedef enum logic [2:0] {
    PLCFG_LEN_4 = 3'h0,
    PLCFG_LEN_8 = 3'h1,
    PLCFG_LEN_16 = 3'h2,
    PLCFG_LEN_24 = 3'h3,
    PLCFG_LEN_32 = 3'h4,
    PLCFG_LEN_40 = 3'h5,
    PLCFG_LEN_48 = 3'h6,
    PLCFG_LEN_64 = 3'h7
  } plcfg_len_t;
  // Start-up progress of the PLL enable toggle, Gray coded
  typedef enum logic [1:0] {
    PLCFG_PU_RESET = 2'h0,
    PLCFG_PU_LOW = 2'h1,
    PLCFG_PU_LOCKED = 2'h3
  } plcfg_pu_t;
endpackage

// ### logic/plcfg_len_decode.sv
// Pattern length code to bit depth decoder
`timescale 1ns/1ns
`default_nettype none
module plcfg_len_decode
  import plcfg_pkg::*;
(
  input wire logic [2:0] code_in,
  output logic [PLCFG_DEPTH_W-1:0] depth_out
);
  always_comb begin
    unique case (plcfg_len_t'(code_in))
      PLCFG_LEN_4: depth_out = 7'h04;
      PLCFG_LEN_8: depth_out = 7'h08;
      PLCFG_LEN_16: depth_out = 7'h10;
      PLCFG_LEN_24: depth_out = 7'h18;
      PLCFG_LEN_32: depth_out = 7'h20;
      PLCFG_LEN_40: depth_out = 7'h28;
      PLCFG_LEN_48: depth_out = 7'h30;
      PLCFG_LEN_64: depth_out = 7'h40;
    endcase
  end
endmodule
`default_nettype wire

// ### logic/plcfg_top.sv
// Pattern length and PLL reference configuration register bank
`timescale 1ns/1ns
`default_nettype none
module plcfg_top
  import plcfg_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out,
  output logic [PLCFG_DEPTH_W-1:0] pattern_depth_out,
  output logic [2:0] pattern_length_field_out,
  output logic ref_single_ended_out,
  output logic ref_differential_out,
  output logic pll_run_out,
  output logic startup_done_out
);
  // ****************************************
  // Registers
  // ****************************************
  logic [PLCFG_CFG_W-1:0] cfg_reg;
  logic [7:0] refsel_reg;
  logic [PLCFG_DEPTH_W-1:0] depth_next;
  plcfg_pu_t pu_reg;
  logic wr_cfg;
  logic wr_ref;
  logic pll_enable_bit;
  logic pll_reference_source_select;

  assign wr_cfg = wr_in && (addr_in == PLCFG_CFG_OFFS);
  assign wr_ref = wr_in && (addr_in == PLCFG_REFSEL_OFFS);
  assign pll_enable_bit = cfg_reg[PLCFG_PLLEN_BIT];
  assign pll_reference_source_select = refsel_reg[PLCFG_REFSEL_BIT];

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_reg <= PLCFG_CFG_RESET;
    end else if (wr_cfg) begin
      cfg_reg <= wdata_in[PLCFG_CFG_W-1:0];
    end
  end

  // Reserved bits are stored as written; software is expected to keep them 0
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      refsel_reg <= PLCFG_REFSEL_RESET;
    end else if (wr_ref) begin
      refsel_reg <= wdata_in[7:0];
    end
  end

  // ****************************************
  // Shared pattern depth
  // ****************************************
  plcfg_len_decode u_dec (
    .code_in(cfg_reg[PLCFG_PLEN_MSB:PLCFG_PLEN_LSB]),
    .depth_out(depth_next)
  );

  // A single depth for all channels, no per-channel copy
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pattern_depth_out <= 7'h04;
      pattern_length_field_out <= 3'h0;
    end else begin
      pattern_depth_out <= depth_next;
      pattern_length_field_out <= cfg_reg[PLCFG_PLEN_MSB:PLCFG_PLEN_LSB];
    end
  end

  // ****************************************
  // Reference select and PLL enable
  // ****************************************
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ref_single_ended_out <= 1'b0;
      ref_differential_out <= 1'b1;
    end else begin
      ref_single_ended_out <= pll_reference_source_select;
      ref_differential_out <= !pll_reference_source_select;
    end
  end

  // PLL held off under reset so the 0-then-1 toggle always starts clean
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pll_run_out <= 1'b0;
    end else begin
      pll_run_out <= pll_enable_bit;
    end
  end

  // Tracks the host's low-then-high enable sequence after reset release
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pu_reg <= PLCFG_PU_RESET;
    end else if (wr_cfg) begin
      unique case (pu_reg)
        PLCFG_PU_RESET: begin
          if (!wdata_in[PLCFG_PLLEN_BIT]) begin
            pu_reg <= PLCFG_PU_LOW;
          end
        end
        PLCFG_PU_LOW: begin
          if (wdata_in[PLCFG_PLLEN_BIT]) begin
            pu_reg <= PLCFG_PU_LOCKED;
          end
        end
        PLCFG_PU_LOCKED: begin
          pu_reg <= PLCFG_PU_LOCKED;
        end
        default: begin
          pu_reg <= PLCFG_PU_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      startup_done_out <= 1'b0;
    end else begin
      startup_done_out <= (pu_reg == PLCFG_PU_LOCKED);
    end
  end

  // ****************************************
  // Read port, unmapped reads give zero
  // ****************************************
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= 16'h0000;
    end else if (rd_in) begin
      unique case (addr_in)
        PLCFG_CFG_OFFS: rdata_out <= {2'h0, cfg_reg};
        PLCFG_REFSEL_OFFS: rdata_out <= {8'h00, refsel_reg};
        PLCFG_STATUS_OFFS: begin
          rdata_out <= {5'h00, pll_run_out, startup_done_out,
                        ref_single_ended_out, 1'b0, pattern_depth_out};
        end
        default: rdata_out <= 16'h0000;
      endcase
    end else begin
      rdata_out <= 16'h0000;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_depth64;
    @(posedge clk_in) disable iff (rst_in)
      (wr_cfg && wdata_in[2:0] == 3'h7) |-> ##2 (pattern_depth_out == 7'h40);
  endproperty
  a_depth64: assert property (p_depth64)
    else $error("depth not 64");

  property p_depth4;
    @(posedge clk_in) disable iff (rst_in)
      (wr_cfg && wdata_in[2:0] == 3'h0) |-> ##2 (pattern_depth_out == 7'h04);
  endproperty
  a_depth4: assert property (p_depth4)
    else $error("depth not 4");

  property p_depth40;
    @(posedge clk_in) disable iff (rst_in)
      (wr_cfg && wdata_in[2:0] == 3'h5) |-> ##2 (pattern_depth_out == 7'h28);
  endproperty
  a_depth40: assert property (p_depth40)
    else $error("depth not 40");

  property p_depth24;
    @(posedge clk_in) disable iff (rst_in)
      (wr_cfg && wdata_in[2:0] == 3'h3) |-> ##2 (pattern_depth_out == 7'h18);
  endproperty
  a_depth24: assert property (p_depth24)
    else $error("depth not 24");

  // The shared code and the shared depth move together
  property p_len_shared;
    @(posedge clk_in) disable iff (rst_in)
      (wr_cfg && wdata_in[2:0] == 3'h6) |->
        ##2 (pattern_length_field_out == 3'h6 && pattern_depth_out == 7'h30);
  endproperty
  a_len_shared: assert property (p_len_shared)
    else $error("length and depth disagree");

  property p_ref_diff;
    @(posedge clk_in) disable iff (rst_in)
      (wr_ref && !wdata_in[0]) |-> ##2 (ref_differential_out &&
                                         !ref_single_ended_out);
  endproperty
  a_ref_diff: assert property (p_ref_diff)
    else $error("ref not diff");

  property p_ref_se;
    @(posedge clk_in) disable iff (rst_in)
      (wr_ref && wdata_in[0]) |-> ##2 (ref_single_ended_out &&
                                        !ref_differential_out);
  endproperty
  a_ref_se: assert property (p_ref_se)
    else $error("ref not single");

  property p_pll_off;
    @(posedge clk_in) disable iff (rst_in)
      (wr_cfg && !wdata_in[PLCFG_PLLEN_BIT]) |-> ##2 !pll_run_out;
  endproperty
  a_pll_off: assert property (p_pll_off)
    else $error("pll still on");

  property p_pll_on;
    @(posedge clk_in) disable iff (rst_in)
      (wr_cfg && wdata_in[PLCFG_PLLEN_BIT]) |-> ##2 pll_run_out;
  endproperty
  a_pll_on: assert property (p_pll_on)
    else $error("pll not on");

  property p_seq;
    @(posedge clk_in) disable iff (rst_in)
      (pu_reg == PLCFG_PU_LOW && wr_cfg && wdata_in[PLCFG_PLLEN_BIT])
        |-> ##2 startup_done_out;
  endproperty
  a_seq: assert property (p_seq)
    else $error("startup not done");

  property p_rd_ref;
    @(posedge clk_in) disable iff (rst_in)
      (rd_in && addr_in == PLCFG_REFSEL_OFFS && !wr_in) |=>
        (rdata_out == {8'h00, $past(refsel_reg)});
  endproperty
  a_rd_ref: assert property (p_rd_ref)
    else $error("bad ref read");
endmodule
`default_nettype wire

// ### verif/plcfg_host_model.sv
// Host model that programs the config block over its register port
`timescale 1ns/1ns
`default_nettype none
module plcfg_host_model
  import plcfg_pkg::*;
(
  input wire logic clk_in,
  input wire logic [15:0] rdata_in,
  output logic [7:0] addr_out,
  output logic [15:0] wdata_out,
  output logic wr_out,
  output logic rd_out
);
  initial begin
    addr_out = 8'h00;
    wdata_out = 16'h0000;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= (a == PLCFG_REFSEL_OFFS) ? (d & 16'h0001) : d;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe edge; take it
  // once it has settled there, before the next edge clears it
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    #1;
    d = rdata_in;
  endtask
endmodule
`default_nettype wire

// ### verif/plcfg_top_tb_top.sv
// Self-checking bench for the pattern length and PLL reference config block
`timescale 1ns/1ns
`default_nettype none
module plcfg_top_tb_top;
  import plcfg_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] addr;
  logic [15:0] wdata, rdata;
  logic wr_s, rd_s, single, diff, pll_run, done;
  logic [PLCFG_DEPTH_W-1:0] depth;
  logic [2:0] len_field;
  int err_count = 0;
  int n_checks = 0;
  int cfg_m, ref_m, seen0, done_m;
  int dt[8] = '{4, 8, 16, 24, 32, 40, 48, 64};
  logic [15:0] v;
  always #10 clk_in = ~clk_in;
  plcfg_host_model plcfg_host_model_i (.clk_in(clk_in), .rdata_in(rdata),
    .addr_out(addr), .wdata_out(wdata), .wr_out(wr_s), .rd_out(rd_s));
  plcfg_top plcfg_top_i (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr_s), .rd_in(rd_s), .rdata_out(rdata),
    .pattern_depth_out(depth), .pattern_length_field_out(len_field),
    .ref_single_ended_out(single), .ref_differential_out(diff),
    .pll_run_out(pll_run), .startup_done_out(done));
  // ****************************************
  // Checking and model
  // ****************************************
  task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [15:0] stat_m();
    return 16'(dt[cfg_m & 7] | (ref_m << 8) | (done_m << 9)
      | (((cfg_m >> 10) & 1) << 10));
  endfunction
  // Compares every block output except rdata against the value the model expects
  task automatic chk_outs();
    check("depth", 16'(depth), 16'(dt[cfg_m & 7]));
    check("length", 16'(len_field), 16'(cfg_m & 7));
    check("single", 16'(single), 16'(ref_m));
    check("diff", 16'(diff), 16'(ref_m ^ 1));
    check("pll", 16'(pll_run), 16'((cfg_m >> 10) & 1));
    check("startup", 16'(done), 16'(done_m));
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    plcfg_host_model_i.wr_reg(a, d);
    if (a == PLCFG_CFG_OFFS) begin
      cfg_m = int'(d[13:0]);
      if (d[10] == 1'b0) seen0 = 1;
      else if (seen0 == 1) done_m = 1;
    end
    if (a == PLCFG_REFSEL_OFFS) ref_m = int'(d[0]);
    repeat (2) @(posedge clk_in);
    #1;
    chk_outs();
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    plcfg_host_model_i.rd_reg(a, v);
    check("rdata", v, exp);
  endtask
  task automatic do_reset();
    rst_in <= 1'b1;
    cfg_m = 0;
    ref_m = 0;
    seen0 = 0;
    done_m = 0;
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    #1;
    chk_outs();
    rd(PLCFG_CFG_OFFS, 16'h0000);
    rd(PLCFG_REFSEL_OFFS, 16'h0000);
  endtask
  task automatic tally_and_finish();
    if (err_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    #200000;
    err_count++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(68713));
    do_reset();
    // Enable before any low write must not count as a completed start-up
    wr(PLCFG_CFG_OFFS, 16'h0403);
    wr(PLCFG_CFG_OFFS, 16'h0000);
    wr(PLCFG_CFG_OFFS, 16'h0407);
    for (int c = 0; c < 8; c++) begin
      wr(PLCFG_CFG_OFFS, 16'(($urandom & 16'h3bf8) | 16'h0400 | c));
      rd(PLCFG_CFG_OFFS, 16'(cfg_m));
      rd(PLCFG_STATUS_OFFS, stat_m());
    end
    wr(PLCFG_REFSEL_OFFS, 16'h0001);
    rd(PLCFG_REFSEL_OFFS, 16'h0001);
    rd(PLCFG_STATUS_OFFS, stat_m());
    wr(PLCFG_REFSEL_OFFS, 16'h0000);
    wr(PLCFG_STATUS_OFFS, 16'hffff);
    wr(8'h55, 16'h0000);
    rd(8'h55, 16'h0000);
    rd(PLCFG_STATUS_OFFS, stat_m());
    wr(PLCFG_CFG_OFFS, 16'h0002);
    // Mid-run reset is raised on a clock edge like every other input
    @(posedge clk_in);
    do_reset();
    wr(PLCFG_CFG_OFFS, 16'h0404);
    tally_and_finish();
  end
endmodule
`default_nettype wire
